/* design/rtc_ctrl_cfg.svh */
// constants of the clock control block: addresses, bit positions, times
// assumes a 20 MHz system clock and a 32.768 kHz crystal tick input
`ifndef RTC_CTRL_CFG_SVH
`define RTC_CTRL_CFG_SVH

// system clock period in ns
`define CLK_PERIOD_NS 50
// crystal rate driving the prescaler chain
`define OSC_HZ 32768

// control register addresses on the 4-bit address bus
`define ADDR_ADJ_STAT 4'hD
`define ADDR_OUT_CTRL 4'hE
`define ADDR_CNT_CTRL 4'hF

// adjust/status register bits
`define BIT_ADJ 3
`define BIT_FLAG 2
`define BIT_BUSY 1
`define BIT_HOLD 0
// output control register bits
`define BIT_SEL1 3
`define BIT_SEL0 2
`define BIT_MODE 1
`define BIT_MASK 0
// counting control register bits
`define BIT_TEST 3
`define BIT_FMT24 2
`define BIT_STOP 1
`define BIT_DCLR 0

// reset value of all control bits
`define CTRL_RST 4'h0

// adjust bit hold time, least time, rounded up
`define ADJ_TIME_NS 76300
`define ADJ_CYCLES ((`ADJ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// constant-period pulse width
`define PULSE_TIME_NS 7812500
`define PULSE_CYCLES (`PULSE_TIME_NS / `CLK_PERIOD_NS)

// prescaler stage end values: osc to 8192 Hz, 8192 Hz to 256 Hz, 256 Hz to 1 Hz
`define PRE_LO_TOP 2'h3
`define PRE_MID_TOP 5'h1F
`define PRE_TOP_TOP 8'hFF
// 256 Hz ticks per 1/64 second, minus one
`define SUB64_LAST 2'h3
// time counter limits
`define SEC_TOP 6'h3B
`define SEC_HALF 6'h1E
`define MIN_TOP 6'h3B
`define HOUR24_TOP 5'h17
`define HOUR12_TOP 5'h0B

`endif

/* design/rtc_pkg.sv */
// types shared by the clock control block
// assumes nothing beyond a SystemVerilog compiler
package rtc_pkg;
   // one data nibble of the parallel port
   typedef logic [3:0] nibble_t;
   // period selections of the event output
   typedef enum logic [1:0] {
      PER_64HZ = 2'h0,
      PER_SEC = 2'h1,
      PER_MIN = 2'h2,
      PER_HOUR = 2'h3
   } period_e;
endpackage

/* design/mod_cnt.sv */
// wrapping counter with clear, used for prescaler stages and time counters
// assumes a synchronised active-low reset from the enclosing block
`timescale 1ns/1ps
module mod_cnt #(
   parameter int W = 4
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic inc,
   input wire logic [W-1:0] top_val,
   output logic [W-1:0] count,
   output logic wrap
);
   // count register
   logic [W-1:0] cnt_ff;

   // wrap when stepping past the top value
   assign wrap = inc && !clr && (cnt_ff >= top_val);
   assign count = cnt_ff;

   // clear wins, then wrap to zero, then step
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (clr || wrap) begin
         cnt_ff <= '0;
      end else if (inc) begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end
endmodule

/* design/rtc_ctrl.sv */
// control logic of a 4-bit real-time clock: event output, adjust, prescaler
// assumes osc_tick pulses once per crystal period, synchronous to clk_sys
// Summary of operation
// - flag reads high exactly while pin low
// - writing flag low releases pin
// - constant mode: fixed 7.8125ms low pulse per event
// - adjust: 30-59 carries minute, seconds zeroed
// - adjust bit self-clears after 76.3us
// - mask high blocks pin going low
// - interrupt mode: mask releases already-low pin
// - constant mode: mask never cuts pulse short
// - mode bit: high interrupt, low constant
// - two select bits choose event period
// - events coincide with counter carries
// - divider clear holds 256Hz-1s stages
// - high-active chip select low forces divider clear bit low
// - stop freezes chain from 8192Hz on
// - format bit selects 24h or 12h
// - chain runs from 32.768kHz crystal
// - period applies both modes, widths differ
`timescale 1ns/1ps
`include "rtc_ctrl_cfg.svh"
module rtc_ctrl #(
   parameter int PULSE_CYC = `PULSE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic osc_tick,
   input wire logic chip_sel_b,
   input wire logic high_active_chip_select,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic [3:0] addr,
   input wire rtc_pkg::nibble_t data_in,
   output rtc_pkg::nibble_t data_out,
   output logic data_oe_b,
   output logic periodic_event_output,
   output logic periodic_event_output_oe_b,
   output logic [5:0] sec_count,
   output logic [5:0] min_count,
   output logic [4:0] hour_count,
   output logic pm_ind
);
   import rtc_pkg::*;

   // reset release synchroniser
   logic rst_meta_ff, rst_n_ff;
   // control bits
   logic hold_ff, adj_ff, mask_ff, mode_ff, stop_ff, fmt24_ff, test_ff, dclr_ff;
   period_e period_ff;
   // adjust hold counter
   logic [10:0] adj_cnt_ff;
   // interrupt latch and pulse width counter
   logic flag_ff;
   logic [17:0] pulse_cnt_ff;
   // registered pin state and its enable copy
   logic pin_low_ff, pin_oe_b_ff, pin_val_ff;
   // parallel port output registers
   nibble_t data_out_ff;
   logic data_oe_b_ff;
   logic wr_b_prev_ff;
   logic pm_ff;
   // bus decode
   logic sel, wr_go, rd_go;
   logic wr_d, wr_e, wr_f, clr_wr, adj_go, adj_carry;
   // prescaler and counter taps
   logic [1:0] pre_lo;
   logic [4:0] pre_mid;
   logic [7:0] pre_top;
   logic lo_wrap, mid_wrap, top_wrap, sec_wrap, min_wrap, hour_wrap;
   logic tick_64, ev, pulse_act;
   logic [5:0] sec_v, min_v;
   logic [4:0] hour_v;
   logic [17:0] nxt_pulse_cnt;
   logic nxt_flag;

   // two-flop release of the asynchronous reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // port decode: both selects active, write taken on wr_b falling
   assign sel = !chip_sel_b && high_active_chip_select;
   assign wr_go = sel && !wr_b && wr_b_prev_ff;
   assign rd_go = sel && !rd_b;
   assign wr_d = wr_go && (addr == `ADDR_ADJ_STAT);
   assign wr_e = wr_go && (addr == `ADDR_OUT_CTRL);
   assign wr_f = wr_go && (addr == `ADDR_CNT_CTRL);
   // flag clear by writing zero to its bit
   assign clr_wr = wr_d && !data_in[`BIT_FLAG];
   // adjust start only when not already running
   assign adj_go = wr_d && data_in[`BIT_ADJ] && !adj_ff;
   assign adj_carry = adj_go && (sec_v >= `SEC_HALF);

   // prescaler: osc to 8192 Hz stage keeps running even when stopped
   mod_cnt #(.W(2)) u_pre_lo (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(1'b0), .inc(osc_tick),
      .top_val(`PRE_LO_TOP), .count(pre_lo), .wrap(lo_wrap)
   );
   // 8192 Hz to 256 Hz, frozen by stop
   mod_cnt #(.W(5)) u_pre_mid (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(1'b0), .inc(lo_wrap && !stop_ff),
      .top_val(`PRE_MID_TOP), .count(pre_mid), .wrap(mid_wrap)
   );
   // 256 Hz to 1 Hz, held by divider clear
   mod_cnt #(.W(8)) u_pre_top (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(dclr_ff), .inc(mid_wrap),
      .top_val(`PRE_TOP_TOP), .count(pre_top), .wrap(top_wrap)
   );
   // seconds, zeroed by adjust
   mod_cnt #(.W(6)) u_sec (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(adj_go), .inc(top_wrap),
      .top_val(`SEC_TOP), .count(sec_v), .wrap(sec_wrap)
   );
   // minutes, stepped by seconds carry or adjust carry
   mod_cnt #(.W(6)) u_min (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(1'b0), .inc(sec_wrap || adj_carry),
      .top_val(`MIN_TOP), .count(min_v), .wrap(min_wrap)
   );
   // hours, limit chosen by format bit
   mod_cnt #(.W(5)) u_hour (
      .clk_sys(clk_sys), .rst_n(rst_n_ff), .clr(1'b0), .inc(min_wrap),
      .top_val(fmt24_ff ? `HOUR24_TOP : `HOUR12_TOP),
      .count(hour_v), .wrap(hour_wrap)
   );
   assign sec_count = sec_v;
   assign min_count = min_v;
   assign hour_count = hour_v;
   assign pm_ind = pm_ff;

   // period event taken from the matching counter carry
   assign tick_64 = mid_wrap && !dclr_ff && (pre_top[1:0] == `SUB64_LAST);
   always_comb begin
      case (period_ff)
         PER_64HZ: ev = tick_64;
         PER_SEC: ev = top_wrap;
         PER_MIN: ev = sec_wrap || adj_carry;
         PER_HOUR: ev = min_wrap;
         default: ev = 1'b0;
      endcase
   end

   // am/pm indicator toggles on each 12-hour wrap
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pm_ff <= 1'b0;
      end else if (!fmt24_ff && hour_wrap) begin
         pm_ff <= !pm_ff;
      end
   end

   // write edge detector for wr_b
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wr_b_prev_ff <= 1'b1;
      end else begin
         wr_b_prev_ff <= wr_b;
      end
   end

   // output control register: select, mode, mask
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         period_ff <= PER_64HZ;
         mode_ff <= 1'b0;
         mask_ff <= 1'b0;
      end else if (wr_e) begin
         period_ff <= period_e'({data_in[`BIT_SEL1], data_in[`BIT_SEL0]});
         mode_ff <= data_in[`BIT_MODE];
         mask_ff <= data_in[`BIT_MASK];
      end
   end

   // counting control register; high-active chip select low forces divider clear bit low
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         test_ff <= 1'b0;
         fmt24_ff <= 1'b0;
         stop_ff <= 1'b0;
         dclr_ff <= 1'b0;
      end else begin
         if (wr_f) begin
            test_ff <= data_in[`BIT_TEST];
            fmt24_ff <= data_in[`BIT_FMT24];
            stop_ff <= data_in[`BIT_STOP];
         end
         if (!high_active_chip_select) begin
            dclr_ff <= 1'b0;
         end else if (wr_f) begin
            dclr_ff <= data_in[`BIT_DCLR];
         end
      end
   end

   // hold bit storage
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         hold_ff <= 1'b0;
      end else if (wr_d) begin
         hold_ff <= data_in[`BIT_HOLD];
      end
   end

   // adjust bit: set by write, held for the fixed time, then self-clears
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         adj_ff <= 1'b0;
         adj_cnt_ff <= '0;
      end else if (adj_go) begin
         adj_ff <= 1'b1;
         adj_cnt_ff <= 11'(`ADJ_CYCLES);
      end else if (adj_cnt_ff != 11'h000) begin
         adj_cnt_ff <= adj_cnt_ff - 11'h001;
         adj_ff <= (adj_cnt_ff != 11'h001);
      end
   end

   // interrupt latch: event sets, zero write clears, set wins
   always_comb begin
      nxt_flag = 1'b0;
      if (mode_ff) begin
         nxt_flag = (ev && !mask_ff) || (flag_ff && !clr_wr);
      end
   end

   // pulse counter: event loads, zero write ends, else counts down
   always_comb begin
      nxt_pulse_cnt = 18'h00000;
      if (!mode_ff) begin
         if (ev && !mask_ff) begin
            nxt_pulse_cnt = 18'(PULSE_CYC);
         end else if (clr_wr) begin
            nxt_pulse_cnt = 18'h00000;
         end else if (pulse_cnt_ff != 18'h00000) begin
            nxt_pulse_cnt = pulse_cnt_ff - 18'h00001;
         end
      end
   end
   assign pulse_act = (pulse_cnt_ff != 18'h00000);

   // latch and pulse state
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         flag_ff <= 1'b0;
         pulse_cnt_ff <= 18'h00000;
      end else begin
         flag_ff <= nxt_flag;
         pulse_cnt_ff <= nxt_pulse_cnt;
      end
   end

   // open-drain pin: low from latch unless masked, or from the pulse
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pin_low_ff <= 1'b0;
         pin_oe_b_ff <= 1'b1;
         pin_val_ff <= 1'b0;
      end else begin
         pin_low_ff <= mode_ff ? (flag_ff && !mask_ff) : pulse_act;
         pin_oe_b_ff <= mode_ff ? !(flag_ff && !mask_ff) : !pulse_act;
         pin_val_ff <= 1'b0;
      end
   end
   assign periodic_event_output = pin_val_ff;
   assign periodic_event_output_oe_b = pin_oe_b_ff;

   // read port: control registers; other addresses read zero
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         data_out_ff <= `CTRL_RST;
         data_oe_b_ff <= 1'b1;
      end else begin
         data_oe_b_ff <= !rd_go;
         case (addr)
            `ADDR_ADJ_STAT: data_out_ff <= {adj_ff, pin_low_ff, 1'b0, hold_ff};
            `ADDR_OUT_CTRL: data_out_ff <= {period_ff, mode_ff, mask_ff};
            `ADDR_CNT_CTRL: data_out_ff <= {test_ff, fmt24_ff, stop_ff, dclr_ff};
            default: data_out_ff <= `CTRL_RST;
         endcase
      end
   end
   assign data_out = data_out_ff;
   assign data_oe_b = data_oe_b_ff;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_ff);

   a_flag_mirror: assert property (rd_go && addr == `ADDR_ADJ_STAT |=>
      data_out_ff[`BIT_FLAG] == !$past(pin_oe_b_ff)) else $error("flag differs from pin");
   a_flag_clear: assert property (clr_wr && !ev |=> ##1 pin_oe_b_ff)
      else $error("pin not released after flag clear");
   a_pulse_len: assert property ($rose(pulse_act) |-> pulse_cnt_ff == 18'(PULSE_CYC))
      else $error("pulse width wrong");
   a_adj_carry: assert property (adj_carry && min_v != `MIN_TOP |=>
      sec_v == 6'h00 && min_v == $past(min_v) + 6'h01) else $error("adjust carry wrong");
   a_adj_low: assert property (adj_go && sec_v < `SEC_HALF |=>
      sec_v == 6'h00 && $stable(min_v)) else $error("adjust without carry wrong");
   a_adj_hold: assert property ($rose(adj_ff) |-> adj_ff [*8])
      else $error("adjust bit dropped early");
   a_adj_end: assert property (adj_ff && adj_cnt_ff == 11'h001 && !adj_go |=> !adj_ff)
      else $error("adjust bit not self-cleared");
   a_int_mask: assert property (mode_ff && mask_ff |=> pin_oe_b_ff)
      else $error("masked interrupt drives pin");
   a_pulse_keep: assert property (pulse_act && pulse_cnt_ff > 18'h00001 && !clr_wr
      && !mode_ff |=> pulse_act) else $error("pulse cut short");
   a_int_event: assert property (mode_ff && ev && !mask_ff && !wr_e |=>
      flag_ff ##1 !pin_oe_b_ff) else $error("interrupt event lost");
   a_div_clear: assert property (!high_active_chip_select |=> !dclr_ff)
      else $error("divider clear not forced low");
   a_div_hold: assert property (dclr_ff |=> pre_top == 8'h00)
      else $error("prescaler not held");
   a_stop_freeze: assert property (stop_ff |=> $stable(pre_mid))
      else $error("prescaler ran while stopped");

   c_adjust: cover property (adj_carry);
   c_pulse: cover property ($fell(pulse_act));
   c_int_clear: cover property (flag_ff && clr_wr);
   c_mask_pulse: cover property (pulse_act && mask_ff);
endmodule

/* dv/rtc_host_model.sv */
// host processor model on the parallel register port of the clock block
// assumes the bench calls wr and rd; strobes move only at falling edges
`timescale 1ns/1ps
module rtc_host_model (
   input wire logic clk_sys,
   output logic chip_sel_b,
   output logic rd_b,
   output logic wr_b,
   output logic [3:0] addr,
   output rtc_pkg::nibble_t data_in,
   input wire rtc_pkg::nibble_t data_out,
   input wire logic data_oe_b
);
   import rtc_pkg::*;

   // idle bus at time zero
   initial begin
      chip_sel_b = 1'b1;
      rd_b = 1'b1;
      wr_b = 1'b1;
      addr = 4'h0;
      data_in = 4'h0;
   end

   // one write cycle, strobe held over the taking edge
   task automatic wr(input logic [3:0] a, input nibble_t d);
      @(negedge clk_sys);
      chip_sel_b = 1'b0;
      addr = a;
      // test bit always written low
      data_in = (a == 4'hF) ? {1'b0, d[2:0]} : d;
      wr_b = 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      wr_b = 1'b1;
      chip_sel_b = 1'b1;
      // released data no longer shows the last value
      data_in = ~data_in;
   endtask

   // one read cycle, data taken one cycle after the read edge
   task automatic rd(input logic [3:0] a, output nibble_t d);
      @(negedge clk_sys);
      chip_sel_b = 1'b0;
      addr = a;
      rd_b = 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys);
      @(negedge clk_sys);
      // undriven bus reads as unknown
      d = (data_oe_b === 1'b0) ? data_out : 4'hX;
      rd_b = 1'b1;
      chip_sel_b = 1'b1;
      addr = ~addr;
   endtask
endmodule

/* dv/rtc_ctrl_tb.sv */
// self-checking bench of the clock control block with a host model
// assumes the crystal tick runs every cycle so 1/64 s is 512 cycles
`timescale 1ns/1ps
module rtc_ctrl_tb;
   import rtc_pkg::*;
   localparam int PW = 20; // shortened pulse width
   localparam int EV = 512; // ticks per 1/64 s
   logic clk_sys, rst_b, osc_tick, high_active_chip_select;
   logic chip_sel_b, rd_b, wr_b, data_oe_b, pin_val, pin_oe_b, pm_ind;
   logic [3:0] addr;
   nibble_t data_in, data_out, r;
   logic [5:0] sec_count, min_count, s;
   logic [4:0] hour_count;
   logic [31:0] seed = 32'h00000060;
   logic [3:0] ra [3] = '{4'hE, 4'hF, 4'h3};
   int num_errors = 0, n_compared = 0, cyc = 0, t0, t;
   // open-drain pin with pull-up
   wire logic pin = pin_oe_b ? 1'b1 : pin_val;

   rtc_ctrl #(.PULSE_CYC(PW)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .osc_tick(osc_tick),
      .chip_sel_b(chip_sel_b), .high_active_chip_select(high_active_chip_select),
      .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe_b(data_oe_b), .periodic_event_output(pin_val),
      .periodic_event_output_oe_b(pin_oe_b), .sec_count(sec_count),
      .min_count(min_count), .hour_count(hour_count), .pm_ind(pm_ind));
   rtc_host_model i_host (.clk_sys(clk_sys), .chip_sel_b(chip_sel_b), .rd_b(rd_b),
      .wr_b(wr_b), .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe_b(data_oe_b));

   // clock and cycle counter
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   // xorshift step for random data
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // expected readback of a written register
   function automatic nibble_t exp_rd(input logic [3:0] a, input nibble_t d);
      return (a == 4'hE) ? d : (a == 4'hF) ? {1'b0, d[2:0]} : 4'h0;
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   // wait for the pin to reach a level, bounded
   task automatic wait_lvl(input logic v, input int lim, output int tt);
      for (int i = 0; i < lim && pin !== v; i++) @(negedge clk_sys);
      chk("pin_reach", v, pin);
      tt = cyc;
   endtask
   // pin must keep a level for n cycles
   task automatic hold_lvl(input logic v, input int n);
      int k;
      k = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (pin !== v) k++;
      end
      chk("pin_hold", 0, k);
   endtask
   task automatic tally_and_finish;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog: a clean run needs about 75000 cycles
   initial begin
      repeat (90000) @(posedge clk_sys);
      num_errors++;
      $display("ERROR watchdog expected done seen hang");
      tally_and_finish();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      osc_tick = 1'b0;
      high_active_chip_select = 1'b1;
      // two rising edges in reset, release on a falling edge
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (3) @(negedge clk_sys);
      osc_tick = 1'b1;
      // control registers clear after reset
      for (int a = 13; a < 16; a++) begin
         i_host.rd(a[3:0], r);
         chk("reset_reg", 0, r);
      end
      // random readback, unmapped address included
      repeat (6) begin
         seed = xs(seed);
         // hours stay at zero here, so a format change leaves nothing to rewrite
         i_host.wr(ra[seed % 3], seed[7:4]);
         i_host.rd(ra[seed % 3], r);
         chk("readback", exp_rd(ra[seed % 3], seed[7:4]), r);
      end
      // trim setup: only period bits, constant mode
      i_host.wr(4'hE, 4'h0);
      i_host.wr(4'hF, 4'h0);
      // let a pulse left over from the random writes finish first
      wait_lvl(1, 30, t);
      wait_lvl(0, 700, t0);
      wait_lvl(1, 30, t);
      chk("pulse_width", PW, 16'(t - t0));
      wait_lvl(0, 600, t);
      chk("event_period", EV, 16'(t - t0));
      // flag follows pin
      wait_lvl(0, 600, t0);
      i_host.rd(4'hD, r);
      chk("flag_low_pin", 1, r[2]);
      wait_lvl(1, 30, t);
      i_host.rd(4'hD, r);
      chk("flag_open_pin", 0, r[2]);
      // mask in mid-pulse completes the pulse, then blocks
      wait_lvl(0, 600, t0);
      i_host.wr(4'hE, 4'h1);
      chk("pin_masked_pulse", 0, pin);
      wait_lvl(1, 30, t);
      chk("masked_width", PW, 16'(t - t0));
      hold_lvl(1, 1100);
      // interrupt mode holds low until cleared
      i_host.wr(4'hE, 4'h2);
      wait_lvl(0, 600, t0);
      hold_lvl(0, 1100);
      i_host.rd(4'hD, r);
      chk("int_flag", 1, r[2]);
      i_host.wr(4'hE, 4'h3);
      repeat (3) @(negedge clk_sys);
      chk("mask_release", 1, pin);
      hold_lvl(1, 600);
      i_host.wr(4'hE, 4'h2);
      wait_lvl(0, 600, t);
      i_host.wr(4'hD, 4'h0);
      repeat (3) @(negedge clk_sys);
      chk("flag_clear", 1, pin);
      // stop freezes the chain
      s = sec_count;
      i_host.wr(4'hF, 4'h2);
      hold_lvl(1, 1100);
      chk("stop_sec", s, sec_count);
      i_host.wr(4'hF, 4'h0);
      wait_lvl(0, 600, t);
      i_host.wr(4'hD, 4'h0);
      // divider clear holds, select low drops it
      i_host.wr(4'hF, 4'h1);
      hold_lvl(1, 1100);
      @(negedge clk_sys);
      high_active_chip_select = 1'b0;
      repeat (2) @(negedge clk_sys);
      high_active_chip_select = 1'b1;
      t0 = cyc;
      i_host.rd(4'hF, r);
      chk("dclr_forced", 0, r);
      s = sec_count;
      for (int i = 0; i < 34000 && sec_count === s; i++) @(negedge clk_sys);
      t = cyc;
      chk("sec_step", s + 6'h01, sec_count);
      // 256 Hz stage keeps its phase, so the first second may be one tick short
      chk("sec_time", 1, 16'((t - t0) inside {[32630:32772]}));
      // one-second events in constant mode, a full second between carries
      i_host.wr(4'hE, 4'h4);
      s = sec_count;
      for (int i = 0; i < 34000 && sec_count === s; i++) @(negedge clk_sys);
      chk("sec_period", 32768, 16'(cyc - t));
      t0 = cyc;
      wait_lvl(0, 4, t);
      chk("sec_event", 1, 16'(t - t0));
      // adjust below 30 s: no carry, bit self-clears
      i_host.wr(4'hD, 4'h8);
      i_host.rd(4'hD, r);
      chk("adj_set", 1, r[3]);
      repeat (1510) @(negedge clk_sys);
      i_host.rd(4'hD, r);
      chk("adj_held", 1, r[3]);
      repeat (12) @(negedge clk_sys);
      i_host.rd(4'hD, r);
      chk("adj_done", 0, r[3]);
      chk("adj_sec", 0, sec_count);
      chk("adj_min", 0, min_count);
      tally_and_finish();
   end
endmodule
